// ==== design/flash_status_poller.sv ====
// Host controller that polls flash write status bits and reports outcome
`timescale 1ns/1ps
// How it works
// RULE1: read status twice, compare toggle bit
// RULE2: device toggle stops when done, data follows
// RULE3: still toggling: check timeout flag, retest
// RULE4: retest toggling with timeout: fail, reset
// RULE5: every new check starts from first read
// RULE6: device raises timeout flag past limit
// RULE7: device halts on zero to one program
// RULE8: after timeout failure send reset command
// RULE9: window flag low then high, restarted
// RULE10: window applies to sector erase only
// RULE11: window flag ignorable if commands fast
// RULE12: window high: device ignores other commands
// RULE13: check window before and after erase command
// RULE14: poll at the program or sector address
// RULE15: device polling bit complements until done
// RULE16: device first toggle inverts every read
// RULE17: device second toggle inverts in erase sectors
// RULE18: device ready busy low while working
module flash_status_poller
  import flash_status_pkg::*;
#(
  parameter int ADDR_WIDTH = 19 // Flash address width
)(
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  // AXI4-Lite slave
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // Flash pins
  output logic [ADDR_WIDTH-1:0] FLASH_ADDR_O,
  output logic [7:0] FLASH_DQ_O,
  output logic FLASH_DQ_OE_O,
  input wire logic [7:0] FLASH_DQ_I,
  output logic FLASH_CE_N_O,
  output logic FLASH_OE_N_O,
  output logic FLASH_WE_N_O,
  input wire logic FLASH_READY_BUSY_I,
  // Interrupt
  output logic IRQ_O
);
  import flash_status_pkg::*;

  // Whole module state
  typedef struct packed {
    state_t state; // Sequencer state
    logic [3:0] cnt; // Strobe cycle counter
    logic [7:0] first_data; // Data of the first status read
    logic [7:0] last_data; // Most recent read data
    logic [ADDR_WIDTH-1:0] addr; // Poll and command address
    logic [7:0] wdata; // Command data
    logic [EV_WIDTH-1:0] status; // Sticky events
    logic [EV_WIDTH-1:0] mask; // Interrupt mask
    logic busy; // Sequence in progress
    logic erase_cmd; // Current write is an extra sector erase
    logic win_before; // Window flag seen before the erase command
    logic aw_held; // Write address accepted
    logic w_held; // Write data accepted
    logic [7:0] aw_addr; // Held write address
    logic [31:0] w_data; // Held write data
    logic bvalid; // Write response pending
    logic rvalid; // Read response pending
    logic [31:0] rdata; // Read response data
    logic ce_n; // Chip enable
    logic oe_n; // Output enable
    logic we_n; // Write enable
    logic dq_oe; // Data bus drive
  } regs_t;

  regs_t r; // Registered state
  regs_t next_r; // Next state

  // Toggle comparison between two reads
  function automatic logic toggled(input logic [7:0] a, input logic [7:0] b);
    toggled = a[TOGGLE1_BIT] != b[TOGGLE1_BIT];
  endfunction

  logic strobe_done; // Strobe held long enough
  logic [EV_WIDTH-1:0] ev; // Events raised this cycle
  logic wr_fire; // Register write taken
  logic [EV_WIDTH-1:0] clr; // Write-one-to-clear bits

  assign strobe_done = r.cnt == 4'(STROBE_CYCLES - 1);
  assign wr_fire = r.aw_held && r.w_held && !r.bvalid;

  // Next-state logic
  always_comb
  begin
    next_r = r;
    ev = '0;
    clr = '0;
    // Write channels accepted independently
    if (S_AXI_AWVALID_I && !r.aw_held)
    begin
      next_r.aw_held = 1'b1;
      next_r.aw_addr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && !r.w_held)
    begin
      next_r.w_held = 1'b1;
      next_r.w_data = S_AXI_WDATA_I;
    end
    if (r.bvalid && S_AXI_BREADY_I)
      next_r.bvalid = 1'b0;
    // Register write decode
    if (wr_fire)
    begin
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
      next_r.bvalid = 1'b1;
      unique case (r.aw_addr)
        STATUS_OFFSET: clr = r.w_data[EV_WIDTH-1:0];
        MASK_OFFSET: next_r.mask = r.w_data[EV_WIDTH-1:0];
        ADDR_OFFSET: if (!r.busy) next_r.addr = r.w_data[ADDR_WIDTH-1:0];
        WDATA_OFFSET: if (!r.busy) next_r.wdata = r.w_data[7:0];
        CTRL_OFFSET:
          if (!r.busy)
          begin
            // Every check starts at the first read
            if (r.w_data[CTRL_ERASE_BIT]) // see RULE13
            begin
              next_r.busy = 1'b1;
              next_r.erase_cmd = 1'b1;
              next_r.state = ST_WIN_BEFORE;
            end
            else if (r.w_data[CTRL_WRITE_BIT])
            begin
              next_r.busy = 1'b1;
              next_r.erase_cmd = 1'b0;
              next_r.state = ST_WR_CMD;
            end
            else if (r.w_data[CTRL_POLL_BIT]) // see RULE5
            begin
              next_r.busy = 1'b1;
              next_r.state = ST_RD_FIRST;
            end
          end
        default: ;
      endcase
    end
    // Read channel
    if (r.rvalid && S_AXI_RREADY_I)
      next_r.rvalid = 1'b0;
    else if (S_AXI_ARVALID_I && !r.rvalid)
    begin
      next_r.rvalid = 1'b1;
      unique case (S_AXI_ARADDR_I)
        CTRL_OFFSET: next_r.rdata = {31'h0, r.busy};
        STATUS_OFFSET: next_r.rdata = {29'h0, r.status};
        MASK_OFFSET: next_r.rdata = {29'h0, r.mask};
        ADDR_OFFSET: next_r.rdata = 32'(r.addr);
        STATE_OFFSET: next_r.rdata = {22'h0, FLASH_READY_BUSY_I, r.busy, r.last_data};
        WDATA_OFFSET: next_r.rdata = {24'h0, r.wdata};
        default: next_r.rdata = 32'h0;
      endcase
    end
    // Flash sequencer; each access holds its strobe STROBE_CYCLES - 1 clocks
    next_r.cnt = (r.state == ST_IDLE || r.state == ST_FINISH || strobe_done) ? 4'h0
      : r.cnt + 4'h1;
    unique case (r.state)
      ST_IDLE: ;
      ST_RD_FIRST, ST_RD_SECOND, ST_RD_THIRD, ST_RD_FOURTH, ST_WIN_BEFORE, ST_WIN_AFTER:
      begin
        // Reads use the programmed or erasing sector address
        next_r.ce_n = 1'b0; // see RULE14
        next_r.oe_n = 1'b0;
        next_r.we_n = 1'b1;
        next_r.dq_oe = 1'b0;
        if (strobe_done)
        begin
          next_r.oe_n = 1'b1;
          next_r.ce_n = 1'b1;
          next_r.last_data = FLASH_DQ_I;
          unique case (r.state)
            ST_RD_FIRST:
            begin
              next_r.first_data = FLASH_DQ_I;
              next_r.state = ST_RD_SECOND; // see RULE1
            end
            ST_RD_SECOND:
              if (!toggled(r.first_data, FLASH_DQ_I)) // see RULE1
              begin
                ev[EV_DONE_BIT] = 1'b1;
                next_r.state = ST_FINISH;
              end
              else if (FLASH_DQ_I[TIMEOUT_BIT]) // see RULE3
                next_r.state = ST_RD_THIRD;
              else
                next_r.state = ST_RD_FIRST; // Keep polling from the top
            ST_RD_THIRD:
            begin
              next_r.first_data = FLASH_DQ_I;
              next_r.state = ST_RD_FOURTH; // see RULE3
            end
            ST_RD_FOURTH:
              if (toggled(r.first_data, FLASH_DQ_I)) // see RULE4
                next_r.state = ST_WR_RESET;
              else
              begin
                ev[EV_DONE_BIT] = 1'b1;
                next_r.state = ST_FINISH;
              end
            ST_WIN_BEFORE: // see RULE13
            begin
              next_r.win_before = FLASH_DQ_I[WINDOW_BIT]; // see RULE13
              next_r.state = ST_WR_CMD;
            end
            default:
            begin
              // Window high before or after the command: may be rejected
              if (FLASH_DQ_I[WINDOW_BIT] || r.win_before) // see RULE13
                ev[EV_REJECT_BIT] = 1'b1;
              next_r.state = ST_RD_FIRST;
            end
          endcase
        end
      end
      ST_WR_CMD, ST_WR_RESET:
      begin
        next_r.ce_n = 1'b0;
        next_r.oe_n = 1'b1;
        next_r.we_n = 1'b0;
        next_r.dq_oe = 1'b1;
        if (strobe_done)
        begin
          next_r.ce_n = 1'b1;
          next_r.we_n = 1'b1;
          next_r.dq_oe = 1'b0;
          if (r.state == ST_WR_RESET)
          begin
            ev[EV_FAIL_BIT] = 1'b1; // see RULE8
            next_r.state = ST_FINISH;
          end
          else if (r.erase_cmd)
            next_r.state = ST_WIN_AFTER;
          else
            next_r.state = ST_FINISH;
        end
      end
      ST_FINISH:
      begin
        next_r.busy = 1'b0;
        next_r.state = ST_IDLE;
      end
      default: next_r.state = ST_IDLE;
    endcase
    // Set wins over clear
    next_r.status = (r.status & ~clr) | ev;
    if (!RESET_N_I)
    begin
      next_r = '0;
      next_r.state = ST_IDLE;
      next_r.mask = MASK_RESET;
      next_r.ce_n = 1'b1;
      next_r.oe_n = 1'b1;
      next_r.we_n = 1'b1;
    end
  end

  // State register
  always_ff @(posedge CLK_I)
  begin
    r <= next_r;
  end

  // Outputs
  assign S_AXI_AWREADY_O = !r.aw_held;
  assign S_AXI_WREADY_O = !r.w_held;
  assign S_AXI_BVALID_O = r.bvalid;
  assign S_AXI_BRESP_O = 2'h0;
  assign S_AXI_ARREADY_O = !r.rvalid;
  assign S_AXI_RVALID_O = r.rvalid;
  assign S_AXI_RDATA_O = r.rdata;
  assign S_AXI_RRESP_O = 2'h0;
  assign FLASH_ADDR_O = r.addr;
  assign FLASH_DQ_O = (r.state == ST_WR_RESET) ? RESET_CMD : r.wdata;
  assign FLASH_DQ_OE_O = r.dq_oe;
  assign FLASH_CE_N_O = r.ce_n;
  assign FLASH_OE_N_O = r.oe_n;
  assign FLASH_WE_N_O = r.we_n;
  assign IRQ_O = |(r.status & r.mask);

  // Second read always follows the first
  two_reads_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // see RULE1
    r.state == ST_RD_FIRST && strobe_done |=> r.state == ST_RD_SECOND)
    else $error("second status read missing");
  // Toggle with timeout goes to retest
  retest_timeout_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // see RULE3
    r.state == ST_RD_SECOND && strobe_done && toggled(r.first_data, FLASH_DQ_I)
    && FLASH_DQ_I[TIMEOUT_BIT] |=> r.state == ST_RD_THIRD)
    else $error("timeout retest skipped");
  // Retest still toggling sends reset
  fail_reset_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // see RULE4
    r.state == ST_RD_FOURTH && strobe_done && toggled(r.first_data, FLASH_DQ_I)
    |=> r.state == ST_WR_RESET ##4 (FLASH_WE_N_O == 1'b0 && FLASH_DQ_O == RESET_CMD)
    ##1 FLASH_DQ_OE_O == 1'b0)
    else $error("reset command not issued");
  // Failure event only after reset cycle
  fail_event_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // see RULE8
    $rose(r.status[EV_FAIL_BIT]) |-> $past(r.state) == ST_WR_RESET)
    else $error("failure without reset command");
  // Erase command checks window after the write
  window_after_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // see RULE13
    r.state == ST_WR_CMD && strobe_done && r.erase_cmd |=> r.state == ST_WIN_AFTER)
    else $error("window recheck missing");
  // New checks begin at first read
  restart_top_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // see RULE5
    r.state == ST_IDLE && next_r.state inside {ST_RD_SECOND, ST_RD_THIRD, ST_RD_FOURTH}
    |-> 1'b0)
    else $error("check resumed midway");
  // Reads hold the poll address
  poll_addr_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // see RULE14
    r.busy && $stable(r.busy) |-> $stable(FLASH_ADDR_O))
    else $error("poll address moved");
  // Write enable never with output enable
  strobes_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    !(FLASH_WE_N_O == 1'b0 && FLASH_OE_N_O == 1'b0))
    else $error("write and read strobes overlap");
  // Data bus driven through every write strobe
  write_drive_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    !FLASH_WE_N_O |-> FLASH_DQ_OE_O)
    else $error("write strobe without data drive");
  erase_c: cover property (@(posedge CLK_I) r.state == ST_WIN_AFTER && strobe_done);
  done_c: cover property (@(posedge CLK_I) $rose(r.status[EV_DONE_BIT]));
  fail_c: cover property (@(posedge CLK_I) $rose(r.status[EV_FAIL_BIT]));
  reject_c: cover property (@(posedge CLK_I) $rose(r.status[EV_REJECT_BIT]));
endmodule

// ==== design/flash_status_pkg.sv ====
// Constants and types shared by the flash status poller
package flash_status_pkg;
  // Register byte offsets on the control bus
  localparam logic [7:0] CTRL_OFFSET = 8'h00; // Command register
  localparam logic [7:0] STATUS_OFFSET = 8'h04; // Sticky event status
  localparam logic [7:0] MASK_OFFSET = 8'h08; // Interrupt mask
  localparam logic [7:0] ADDR_OFFSET = 8'h0c; // Poll and command address
  localparam logic [7:0] STATE_OFFSET = 8'h10; // Live state and last data
  localparam logic [7:0] WDATA_OFFSET = 8'h14; // Command data word
  // Command register fields
  localparam int CTRL_POLL_BIT = 0; // Start a status check
  localparam int CTRL_WRITE_BIT = 1; // Issue one flash write cycle
  localparam int CTRL_ERASE_BIT = 2; // Issue write and window check
  // Status and mask field positions
  localparam int EV_DONE_BIT = 0; // Operation finished well
  localparam int EV_FAIL_BIT = 1; // Timeout failure, reset sent
  localparam int EV_REJECT_BIT = 2; // Extra sector erase maybe rejected
  localparam int EV_WIDTH = 3; // Number of event bits
  // Status bit positions on the flash data bus
  localparam int POLL_BIT = 7; // data_polling_bit
  localparam int TOGGLE1_BIT = 6; // first_toggle_bit
  localparam int TIMEOUT_BIT = 5; // timeout_flag
  localparam int WINDOW_BIT = 3; // erase_window_flag
  localparam int TOGGLE2_BIT = 2; // second_toggle_bit
  // Reset command data
  localparam logic [7:0] RESET_CMD = 8'hf0;
  // Read and write access length in ns at 20 ns per clock; each strobe is held one clock less
  localparam int CLK_PERIOD_NS = 20;
  localparam int STROBE_NS = 100;
  localparam int STROBE_CYCLES = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Reset values
  localparam logic [EV_WIDTH-1:0] MASK_RESET = 3'h0;
  // Poller states
  typedef enum logic [3:0] {
    ST_IDLE, ST_RD_FIRST, ST_RD_SECOND, ST_RD_THIRD, ST_RD_FOURTH,
    ST_WR_CMD, ST_WR_RESET, ST_WIN_BEFORE, ST_WIN_AFTER, ST_FINISH
  } state_t;
endpackage

// ==== verif/flash_model.sv ====
// Behavioural flash device that answers status reads and takes commands
`timescale 1ns/1ps
module flash_model
(
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [18:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic ready_busy_o
);
  int busy_reads = 0; // Reads that still toggle
  bit stuck = 0; // Toggle without end
  bit tflag = 0; // Timeout flag level
  bit win = 0; // Erase window closed
  bit t1 = 0; // First toggle state
  bit t2 = 0; // Second toggle state
  int writes = 0; // Commands accepted
  int resets = 0; // Reset commands seen
  logic [18:0] ra = '0; // Last read address
  logic [18:0] wa = '0; // Last write address
  logic [7:0] wd = '0; // Last write data
  wire rd_n = ce_n_i | oe_n_i; // Either strobe ends a read
  initial data_o = 8'h5a;
  // Load a new operation
  task start(input int n, input bit s, input bit tf, input bit w);
    busy_reads = n;
    stuck = s;
    tflag = tf;
    win = w;
  endtask
  // Each read start gives fresh status
  always @(negedge rd_n)
  begin
    ra = addr_i;
    if (busy_reads > 0 || stuck)
    begin
      t1 = ~t1;
      if (addr_i[18:16] == 3'h1) t2 = ~t2;
      if (!stuck) busy_reads--;
    end
    data_o = {ready_busy_o ? wd[7] : ~wd[7], t1, tflag, 1'b0, win, t2, 2'b00};
  end
  // Released bus shows no stale value
  always @(posedge rd_n) data_o = ~data_o;
  // Write pulse captured in mid-pulse
  always @(negedge we_n_i)
  begin
    #30;
    if (!ce_n_i)
    begin
      wa = addr_i;
      wd = data_i;
      if (data_i == 8'hf0)
      begin
        resets++;
        stuck = 0;
        tflag = 0;
      end
      else if (!win || data_i == 8'hb0)
      begin
        writes++;
        // Whole-chip erase starts at once, with no acceptance window
        if (data_i == 8'h10) win = 1;
      end
    end
  end
  assign ready_busy_o = !(busy_reads > 0 || stuck);
endmodule

// ==== verif/flash_status_poller_test.sv ====
// Self-checking bench for the flash status poller
`timescale 1ns/1ps
module flash_status_poller_test;
  import flash_status_pkg::*;
  logic clk = 0, rst_n = 0; // Clock and reset
  logic [7:0] awaddr = '0, araddr = '0; // Bus addresses
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0, rdata, a, d, n; // Bus and scratch words
  logic awready, wready, bvalid, arready, rvalid, ce_n, oe_n, we_n, dq_oe, irq, rb;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata_o;
  logic [18:0] faddr;
  logic [7:0] dq_o, dq_i;
  logic [31:0] exp_q[$], msk_q[$]; // Expected reads
  logic [31:0] exp_v, msk_v; // Monitor copies, apart from scratch words
  int n_tests = 0, num_errors = 0, seed = 32'h531a;
  always #10 clk = ~clk;
  flash_status_poller dut_u (.CLK_I(clk), .RESET_N_I(rst_n), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata_o), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .FLASH_ADDR_O(faddr), .FLASH_DQ_O(dq_o), .FLASH_DQ_OE_O(dq_oe),
    .FLASH_DQ_I(dq_i), .FLASH_CE_N_O(ce_n), .FLASH_OE_N_O(oe_n), .FLASH_WE_N_O(we_n),
    .FLASH_READY_BUSY_I(rb), .IRQ_O(irq));
  flash_model flash_u (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(faddr),
    .data_i(dq_o), .data_o(dq_i), .ready_busy_o(rb));
  // Masked compare with count
  task chk(input logic [31:0] got, input logic [31:0] e, input logic [31:0] m);
    n_tests++;
    if ((got & m) !== (e & m))
    begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, e);
    end
  endtask
  // Bus write, address and data offered together
  task wr(input logic [7:0] ad, input logic [31:0] dt);
    awaddr <= ad;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk({30'h0, bresp}, 32'h0, 32'h3);
    bready <= 1'b0;
    @(posedge clk);
  endtask
  // Bus read, expectation queued for the monitor
  task rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    exp_q.push_back(e);
    msk_q.push_back(m);
    do
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rdata = rdata_o;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // Read command register until not busy
  task wait_idle;
    do rd(CTRL_OFFSET, 0, 0); while (rdata[0] !== 1'b0);
  endtask
  // Monitor compares each read that has a nonzero mask with the oldest note
  always @(posedge clk)
  begin
    if (rvalid && rready)
    begin
      exp_v = exp_q.pop_front();
      msk_v = msk_q.pop_front();
      chk({30'h0, rresp}, 32'h0, 32'h3);
      if (msk_v != 0) chk(rdata_o, exp_v, msk_v);
    end
  end
  // Verdict and end of run
  task report_and_stop;
    $display("comparisons %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    repeat (40000) @(posedge clk);
    num_errors++;
    report_and_stop;
  end
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(MASK_OFFSET, 0, 32'h7);
    rd(STATUS_OFFSET, 0, 32'h7);
    rd(8'h20, 0, 32'hffffffff);
    // Toggle stops after a few reads
    flash_u.start(3, 0, 0, 0);
    wr(ADDR_OFFSET, 32'h100);
    wr(CTRL_OFFSET, 32'h1);
    wr(ADDR_OFFSET, 32'h555); // Refused while busy
    wait_idle;
    rd(STATUS_OFFSET, 32'h1, 32'h7);
    rd(ADDR_OFFSET, 32'h100, 32'h7ffff);
    chk(flash_u.ra, 32'h100, 32'h7ffff);
    rd(STATE_OFFSET, 32'h200, 32'h200);
    chk(irq, 0, 1);
    wr(MASK_OFFSET, 32'h7);
    @(posedge clk);
    chk(irq, 1, 1);
    wr(STATUS_OFFSET, 32'h1);
    @(posedge clk);
    chk(irq, 0, 1);
    // Timeout flag up but toggle stops on retest
    flash_u.start(3, 0, 1, 0);
    wr(CTRL_OFFSET, 32'h1);
    wait_idle;
    rd(STATUS_OFFSET, 32'h1, 32'h7);
    wr(STATUS_OFFSET, 32'h7);
    // Toggle never stops: failure and reset command
    flash_u.start(0, 1, 1, 0);
    wr(CTRL_OFFSET, 32'h1);
    wait_idle;
    rd(STATUS_OFFSET, 32'h2, 32'h7);
    chk(flash_u.resets, 1, 32'hff);
    chk(flash_u.wa, 32'h100, 32'h7ffff);
    chk(irq, 1, 1);
    wr(STATUS_OFFSET, 32'h7);
    // Extra sector erase, window open then closed
    wr(ADDR_OFFSET, 32'h10000);
    wr(WDATA_OFFSET, 32'h30);
    rd(WDATA_OFFSET, 32'h30, 32'hff);
    for (int i = 0; i < 2; i++)
    begin
      n = flash_u.writes;
      flash_u.start(0, 0, 0, i[0]);
      wr(CTRL_OFFSET, 32'h4);
      wait_idle;
      rd(STATUS_OFFSET, i ? 32'h5 : 32'h1, 32'h7);
      chk(flash_u.writes, n + 1 - i, 32'hffff);
      wr(STATUS_OFFSET, 32'h7);
    end
    // Random single write cycles
    repeat (3)
    begin
      a = $random(seed);
      d = $random(seed);
      d[7:4] = 4'h5;
      wr(ADDR_OFFSET, a & 32'h7ffff);
      wr(WDATA_OFFSET, d);
      wr(CTRL_OFFSET, 32'h2);
      wait_idle;
      chk(flash_u.wa, a, 32'h7ffff);
      chk(flash_u.wd, d, 32'hff);
    end
    report_and_stop;
  end
endmodule
